// ===== shared/surv_cmd_regs.svh
// Purpose: constants for the surveillance command interpreter
// Assumes: request bytes arrive with CRC already checked and stripped
// Notes: definitions only
`ifndef SURV_CMD_REGS_SVH
`define SURV_CMD_REGS_SVH
// command codes
`define CMD_FAST_PAGE 8'hb1
`define CMD_SURV_ON 8'ha2
`define CMD_SURV_OFF 8'ha3
`define CMD_SURV_FREEZE 8'ha4
`define CMD_PROTECT 8'ha6
`define CMD_IDENT_WR 8'ha7
// error code for unsupported or out-of-range
`define ERR_GENERIC 8'h0f
// request flag bit positions
`define FLG_RATE 3'd1
`define FLG_INVENT 3'd2
`define FLG_PROTEXT 3'd3
`define FLG_SELECT 3'd4
`define FLG_ADDR 3'd5
`define FLG_OPTION 3'd6
// response flag values
`define RSP_FLAGS_OK 8'h00
`define RSP_FLAGS_ERR 8'h01
// byte offsets of a request
`define OFS_PARAM_PLAIN 5'd3
`define OFS_PARAM_ADDR 5'd11
`define FRAME_BYTES 16
`define SEQ_BYTES 6'd32
// alarm pattern, bytes in the order read, msb of each byte sent first
`define ALARM_SEQ {64'hf4cd460eabe509fe, 64'h178d021c4b82926e, \
    64'h425b5961f6f5d10d, 64'h8f398b48a54eecf7}
`endif

// ===== shared/surv_cmd_pkg.sv
// Purpose: types for the surveillance command interpreter
// Assumes: nothing
// Notes: gray codes along idle -> flags -> body
package surv_cmd_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_FLAGS = 2'b01,
        TX_BODY = 2'b11
    } tx_state_e;
    typedef enum logic [2:0] {
        RSP_NONE = 3'd0,
        RSP_OK = 3'd1,
        RSP_ERR = 3'd2,
        RSP_ALARM = 3'd3,
        RSP_IDENT = 3'd4
    } rsp_kind_e;
endpackage : surv_cmd_pkg

// ===== verilog/surv_cmd.sv
// Purpose: custom surveillance and fast page read command handling of a tag
// Assumes: link coder delivers checked bytes on link_clk, takes reply bytes
// Notes: nv_* inputs reload the persistent state on every reset
// Operation
// - fast page read runs the ordinary page read
// - fast reply at double rate per rate flag
// - request rate, delay standard; single subcarrier reply
// - surveillance on unless frozen
// - surveillance off unless frozen
// - freeze fixes mode and identifier for good
// - protected surveillance needs accepted password first
// - request and reply byte layouts as fixed
// - write-alike timing, either option value accepted
// - plain alarm answers only when surveillance on
// - masked alarm needs mode on and identifier match
// - zero mask length returns stored identifier
// - alarm reply is flags plus fixed pattern
// - alarm silent on error or mode off
// - protect surveillance or family by option flag
// - protection can never be switched off
// - protect command always uses option-clear timing
// - identifier write stores 16 bits, password if protected
// - transmission fault gives silence, wait for next
// - unsupported: error in addressed or selected mode, else silent
// - multi-block read clipped at last user block
// - bad block write aborts, error only when addressed
// - page read keeps inventory mechanism and timing
`timescale 1ns/1ps
`include "surv_cmd_regs.svh"
module surv_cmd
    import surv_cmd_pkg::*;
#(
    parameter logic [7:0] MFG_CODE = 8'h5a,  // arbitrary value
    parameter logic [7:0] ALARM_CODE = 8'hae,
    parameter logic [7:0] NUM_USER_BLOCKS = 8'd16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    input wire logic rx_fault,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready,
    output logic tx_write_like,
    output logic tx_option_timing,
    input wire logic pwd_ok,
    input wire logic nv_surv_on,
    input wire logic nv_surv_lock,
    input wire logic [15:0] nv_ident,
    input wire logic nv_surv_prot,
    input wire logic nv_fam_prot,
    output logic surv_on,
    output logic surv_lock,
    output logic [15:0] surv_identifier,
    output logic surv_prot,
    output logic fam_prot,
    output logic nv_write,
    output logic page_read_start,
    output logic page_read_fast,
    output logic reply_rate_high,
    output logic reply_single_sub,
    input wire logic [7:0] rd_first,
    input wire logic [7:0] rd_count,
    output logic [7:0] rd_count_clipped,
    input wire logic wr_req,
    input wire logic [7:0] wr_block,
    input wire logic wr_block_locked,
    input wire logic wr_addressed,
    output logic wr_abort,
    output logic wr_err_reply
);
    // link domain: frame capture
    logic [7:0] frame_mem [`FRAME_BYTES];  // held still while busy
    logic [4:0] rx_cnt_ff;  // bytes of the frame being received
    logic [4:0] frame_len_ff;  // length of the handed-over frame
    logic rx_bad_ff;  // overflow seen inside this frame
    logic req_tgl_ff;  // flips once per handed-over frame
    logic busy_ff;  // frame handed over, reply not finished
    logic lrst_meta_ff, lrst_ff;  // reset brought into link domain
    logic ack_meta_ff, ack_sync_ff, ack_seen_ff;
    tx_state_e tx_st_ff;
    logic [5:0] tx_idx_ff;  // body byte index
    logic [5:0] body_len;
    logic [7:0] body_byte;
    // mclk domain
    logic req_meta_ff, req_sync_ff, req_seen_ff;
    logic ack_tgl_ff;
    rsp_kind_e rsp_ff;
    logic [7:0] rsp_code_ff;
    logic opt_timing_ff;
    logic new_req;
    localparam logic [255:0] SEQ = `ALARM_SEQ;

    // bit reversal: pattern bytes are written first-sent-left
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction : rev8

    // error reply only when addressed or selected and neither inventory nor protocol extension flag
    function automatic logic err_allowed(input logic [7:0] f);
        return (f[`FLG_ADDR] | f[`FLG_SELECT]) & ~f[`FLG_INVENT] &
            ~f[`FLG_PROTEXT];
    endfunction : err_allowed

    // reset synchroniser into the link clock
    always_ff @(posedge link_clk) begin
        lrst_meta_ff <= reset;
        lrst_ff <= lrst_meta_ff;
    end

    // ack toggle back from mclk, two flops before use
    always_ff @(posedge link_clk) begin
        ack_meta_ff <= ack_tgl_ff;
        ack_sync_ff <= ack_meta_ff;
    end

    // frame capture; a faulty frame is dropped and capture restarts
    always_ff @(posedge link_clk) begin
        if (lrst_ff) begin
            rx_cnt_ff <= 5'd0;
            rx_bad_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            frame_len_ff <= 5'd0;
        end else if (rx_fault) begin
            rx_cnt_ff <= 5'd0;
            rx_bad_ff <= 1'b0;
        end else if (rx_valid && !busy_ff) begin
            if (rx_cnt_ff < 5'(`FRAME_BYTES)) begin
                frame_mem[rx_cnt_ff[3:0]] <= rx_byte;
                rx_cnt_ff <= rx_cnt_ff + 5'd1;
            end else begin
                rx_bad_ff <= 1'b1;  // too long, counted as bit count fault
            end
            if (rx_last) begin
                rx_cnt_ff <= 5'd0;
                rx_bad_ff <= 1'b0;
                // overlong frames never reach the decoder
                if (!rx_bad_ff && rx_cnt_ff < 5'(`FRAME_BYTES)) begin
                    frame_len_ff <= rx_cnt_ff + 5'd1;
                    req_tgl_ff <= ~req_tgl_ff;
                end
            end
        end
    end

    // busy from hand-over until the reply (or silence) is finished
    always_ff @(posedge link_clk) begin
        if (lrst_ff) begin
            busy_ff <= 1'b0;
            ack_seen_ff <= 1'b0;
        end else begin
            ack_seen_ff <= ack_sync_ff;
            if (rx_valid && rx_last && !rx_fault && !busy_ff &&
                    !rx_bad_ff && rx_cnt_ff < 5'(`FRAME_BYTES)) begin
                busy_ff <= 1'b1;
            end else if (tx_st_ff == TX_IDLE && ack_sync_ff != ack_seen_ff
                    && rsp_ff == RSP_NONE) begin
                busy_ff <= 1'b0;  // silent answer
            end else if (tx_st_ff != TX_IDLE && tx_valid && tx_ready &&
                    tx_last) begin
                busy_ff <= 1'b0;  // flags-only replies end here too
            end
        end
    end

    // body length and bytes per reply kind
    always_comb begin
        body_len = 6'd0;
        body_byte = 8'h00;
        unique case (rsp_ff)
            RSP_ERR: begin
                body_len = 6'd1;
                body_byte = rsp_code_ff;
            end
            RSP_IDENT: begin
                body_len = 6'd2;
                body_byte = tx_idx_ff[0] ? surv_identifier[15:8] :
                    surv_identifier[7:0];
            end
            RSP_ALARM: begin
                body_len = `SEQ_BYTES;
                body_byte = rev8(SEQ[8'(255 - 8 * tx_idx_ff) -: 8]);
            end
            default: begin
                body_len = 6'd0;
                body_byte = 8'h00;
            end
        endcase
    end

    // reply sender: flags byte, then body; coder appends crc and eof
    always_ff @(posedge link_clk) begin
        if (lrst_ff) begin
            tx_st_ff <= TX_IDLE;
            tx_idx_ff <= 6'd0;
        end else begin
            unique case (tx_st_ff)
                TX_IDLE: begin
                    tx_idx_ff <= 6'd0;
                    if (ack_sync_ff != ack_seen_ff && rsp_ff != RSP_NONE) begin
                        tx_st_ff <= TX_FLAGS;
                    end
                end
                TX_FLAGS: begin
                    if (tx_ready) begin
                        tx_st_ff <= (body_len == 6'd0) ? TX_IDLE : TX_BODY;
                    end
                end
                TX_BODY: begin
                    if (tx_ready) begin
                        tx_idx_ff <= tx_idx_ff + 6'd1;
                        if (tx_last) begin
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    assign tx_valid = (tx_st_ff != TX_IDLE);
    assign tx_byte = (tx_st_ff == TX_FLAGS) ?
        ((rsp_ff == RSP_ERR) ? `RSP_FLAGS_ERR : `RSP_FLAGS_OK) :
        (tx_st_ff == TX_BODY) ? body_byte : 8'h00;
    assign tx_last = (tx_st_ff == TX_FLAGS && body_len == 6'd0) ||
        (tx_st_ff == TX_BODY && tx_idx_ff == body_len - 6'd1);
    assign tx_write_like = (rsp_ff == RSP_OK || rsp_ff == RSP_ERR);
    assign tx_option_timing = opt_timing_ff;

    // request toggle into mclk, two flops before the edge detector
    always_ff @(posedge mclk) begin
        req_meta_ff <= req_tgl_ff;
        req_sync_ff <= req_meta_ff;
        req_seen_ff <= reset ? 1'b0 : req_sync_ff;
    end
    assign new_req = (req_sync_ff != req_seen_ff) && !reset;

    // decode of a handed-over frame; frame_mem is stable until ack
    logic [7:0] flg, cmd, mlen;
    logic [4:0] pofs;
    logic addr_ok, mode_ok, nxt_opt;
    rsp_kind_e nxt_rsp;
    always_comb begin
        flg = frame_mem[0];
        cmd = frame_mem[1];
        pofs = flg[`FLG_ADDR] ? `OFS_PARAM_ADDR : `OFS_PARAM_PLAIN;
        mlen = frame_mem[pofs[3:0]];
        addr_ok = (frame_mem[2] == MFG_CODE);
        // surveillance change allowed only when not frozen, and after password if protected
        mode_ok = !surv_lock && (!surv_prot || pwd_ok);
        nxt_opt = flg[`FLG_OPTION] && cmd != `CMD_PROTECT;
        nxt_rsp = RSP_NONE;
        if (cmd == ALARM_CODE) begin
            // alarm: any error or mode off keeps the tag quiet
            if (!addr_ok) begin
                nxt_rsp = RSP_NONE;
            end else if (!flg[`FLG_OPTION]) begin
                if (frame_len_ff == pofs && surv_on) begin
                    nxt_rsp = RSP_ALARM;
                end
            end else if (mlen == 8'd0 && frame_len_ff == pofs + 5'd1) begin
                if (surv_on) begin
                    nxt_rsp = RSP_IDENT;
                end
            end else if (mlen == 8'd8 && frame_len_ff == pofs + 5'd2) begin
                if (surv_on && frame_mem[pofs[3:0] + 4'd1] ==
                        surv_identifier[7:0]) begin
                    nxt_rsp = RSP_ALARM;
                end
            end else if (mlen == 8'd16 && frame_len_ff == pofs + 5'd3) begin
                if (surv_on && {frame_mem[pofs[3:0] + 4'd2],
                        frame_mem[pofs[3:0] + 4'd1]} == surv_identifier) begin
                    nxt_rsp = RSP_ALARM;
                end
            end
        end else if (cmd == `CMD_SURV_ON || cmd == `CMD_SURV_OFF ||
                cmd == `CMD_SURV_FREEZE || cmd == `CMD_PROTECT ||
                cmd == `CMD_IDENT_WR) begin
            if (!addr_ok || frame_len_ff != pofs +
                    ((cmd == `CMD_IDENT_WR) ? 5'd2 : 5'd0)) begin
                nxt_rsp = RSP_NONE;  // malformed
            end else if ((cmd == `CMD_PROTECT) ? pwd_ok :
                    (cmd == `CMD_SURV_FREEZE) ? (!surv_prot || pwd_ok) :
                    mode_ok) begin
                nxt_rsp = RSP_OK;
            end else begin
                nxt_rsp = err_allowed(flg) ? RSP_ERR : RSP_NONE;
            end
        end else if (cmd != `CMD_FAST_PAGE) begin
            nxt_rsp = err_allowed(flg) ? RSP_ERR : RSP_NONE;
        end
    end

    // reply descriptor, handed back by the ack toggle
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_ff <= RSP_NONE;
            rsp_code_ff <= 8'h00;
            opt_timing_ff <= 1'b0;
            ack_tgl_ff <= 1'b0;
        end else if (new_req) begin
            rsp_ff <= nxt_rsp;
            rsp_code_ff <= `ERR_GENERIC;
            opt_timing_ff <= nxt_opt;
            ack_tgl_ff <= ~ack_tgl_ff;
        end
    end

    // persistent surveillance state, reloaded on reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            surv_on <= nv_surv_on;
            surv_lock <= nv_surv_lock;
            surv_identifier <= nv_ident;
            surv_prot <= nv_surv_prot;
            fam_prot <= nv_fam_prot;
            nv_write <= 1'b0;
        end else begin
            nv_write <= new_req && nxt_rsp == RSP_OK;
            if (new_req && nxt_rsp == RSP_OK) begin
                unique case (cmd)
                    `CMD_SURV_ON: surv_on <= 1'b1;
                    `CMD_SURV_OFF: surv_on <= 1'b0;
                    `CMD_SURV_FREEZE: surv_lock <= 1'b1;
                    `CMD_IDENT_WR: surv_identifier <=
                        {frame_mem[pofs[3:0] + 4'd1], frame_mem[pofs[3:0]]};
                    // only ever set, nothing clears these
                    `CMD_PROTECT: begin
                        if (flg[`FLG_OPTION]) begin
                            fam_prot <= 1'b1;
                        end else begin
                            surv_prot <= 1'b1;
                        end
                    end
                    default: surv_on <= surv_on;
                endcase
            end
        end
    end

    // fast page read: hand to the base page read engine
    always_ff @(posedge mclk) begin
        if (reset) begin
            page_read_start <= 1'b0;
            page_read_fast <= 1'b0;
            reply_rate_high <= 1'b0;
            reply_single_sub <= 1'b0;
        end else begin
            page_read_start <= new_req && cmd == `CMD_FAST_PAGE &&
                addr_ok && flg[`FLG_INVENT];
            if (new_req && cmd == `CMD_FAST_PAGE) begin
                page_read_fast <= 1'b1;  // double return rate
                reply_rate_high <= flg[`FLG_RATE];
                reply_single_sub <= 1'b1;
            end else if (new_req) begin
                page_read_fast <= 1'b0;
                reply_rate_high <= flg[`FLG_RATE];
                reply_single_sub <= ~flg[0];  // set flag asks for two
            end
        end
    end

    // read clipping and bad-write handling for the block engines
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_count_clipped <= 8'h00;
            wr_abort <= 1'b0;
            wr_err_reply <= 1'b0;
        end else begin
            rd_count_clipped <= (rd_first >= NUM_USER_BLOCKS) ? 8'h00 :
                ({1'b0, rd_first} + {1'b0, rd_count} > {1'b0, NUM_USER_BLOCKS})
                ? NUM_USER_BLOCKS - rd_first : rd_count;
            wr_abort <= wr_req && (wr_block >= NUM_USER_BLOCKS ||
                wr_block_locked);
            wr_err_reply <= wr_req && wr_addressed &&
                (wr_block >= NUM_USER_BLOCKS || wr_block_locked);
        end
    end

    // checks
    p_freeze_holds: assert property (@(posedge mclk) disable iff (reset)
        $past(surv_lock) && surv_lock |-> $stable(surv_on) &&
        $stable(surv_identifier))
        else $error("frozen surveillance state changed");
    p_prot_sticky: assert property (@(posedge mclk) disable iff (reset)
        surv_prot |=> surv_prot)
        else $error("surveillance protection dropped");
    p_on_cmd: assert property (@(posedge mclk) disable iff (reset)
        new_req && cmd == `CMD_SURV_ON && nxt_rsp == RSP_OK |=> surv_on)
        else $error("surveillance on command ignored");
    p_off_cmd: assert property (@(posedge mclk) disable iff (reset)
        new_req && cmd == `CMD_SURV_OFF && !surv_lock && !surv_prot &&
        addr_ok && frame_len_ff == pofs |=> !surv_on)
        else $error("surveillance off command ignored");
    p_alarm_silent: assert property (@(posedge mclk) disable iff (reset)
        new_req && cmd == ALARM_CODE && !surv_on |=> rsp_ff == RSP_NONE)
        else $error("alarm answered with mode off");
    p_pwd_needed: assert property (@(posedge mclk) disable iff (reset)
        new_req && surv_prot && !pwd_ok && cmd == `CMD_IDENT_WR
        |=> $stable(surv_identifier) ##1 $stable(surv_identifier))
        else $error("identifier written without password");
    p_unsup_err: assert property (@(posedge mclk) disable iff (reset)
        new_req && cmd == 8'hc5 && err_allowed(flg) |=>
        rsp_ff == RSP_ERR && rsp_code_ff == `ERR_GENERIC)
        else $error("unsupported command not flagged");
    p_wr_abort: assert property (@(posedge mclk) disable iff (reset)
        wr_req && wr_block >= NUM_USER_BLOCKS && !wr_addressed
        |=> wr_abort && !wr_err_reply)
        else $error("bad block write not aborted quietly");
    p_clip: assert property (@(posedge mclk) disable iff (reset)
        rd_first < NUM_USER_BLOCKS ##1 1'b1 |->
        {1'b0, $past(rd_first)} + {1'b0, rd_count_clipped} <=
        {1'b0, NUM_USER_BLOCKS})
        else $error("read ran past last user block");
    p_alarm_len: assert property (@(posedge link_clk) disable iff (lrst_ff)
        tx_st_ff == TX_BODY && rsp_ff == RSP_ALARM && tx_last |->
        tx_idx_ff == 6'd31)
        else $error("alarm pattern length wrong");
    c_alarm: cover property (@(posedge link_clk) rsp_ff == RSP_ALARM &&
        tx_last && tx_ready);
    c_ident: cover property (@(posedge link_clk) rsp_ff == RSP_IDENT &&
        tx_last && tx_ready);
    c_err: cover property (@(posedge mclk) new_req && nxt_rsp == RSP_ERR);
    c_fast: cover property (@(posedge mclk) page_read_start);
endmodule : surv_cmd

// ===== dv/reader_model.sv
// Purpose: interrogator side of the link: sends request bytes, takes replies
// Assumes: CRC is checked and stripped by the coder, so none is sent here
// Notes: between frames rx_byte shows the inverse of the last byte sent
`timescale 1ns/1ps
module reader_model (
    input wire logic link_clk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_last,
    output logic rx_fault,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] got[$]; // reply bytes taken in the last answer
    logic slow = 1'b0; // stall every other cycle when set
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_last = 1'b0;
        rx_fault = 1'b0;
        tx_ready = 1'b0;
    end
    // ready toggles while stalling so each byte waits a link cycle
    always @(posedge link_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    // whole frame, one byte per link edge; flt marks a broken last byte
    task automatic send(input logic [7:0] req[$], input logic flt);
        foreach (req[i]) begin
            @(posedge link_clk);
            rx_valid <= 1'b1;
            rx_byte <= req[i];
            rx_last <= (i == req.size() - 1);
            rx_fault <= flt && (i == req.size() - 1);
        end
        @(posedge link_clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_fault <= 1'b0;
        rx_byte <= ~req[req.size() - 1]; // stale data never looks valid
    endtask : send
    // collect until the last byte or lim quiet cycles (silence)
    task automatic take(input int lim);
        int n;
        n = 0;
        got.delete();
        while (n < lim) begin
            @(posedge link_clk);
            if (tx_valid && tx_ready) begin
                got.push_back(tx_byte);
                n = 0;
                if (tx_last) break;
            end else n++;
        end
    endtask : take
endmodule : reader_model

// ===== dv/tb_rfid_tag_eas_custom_commands.sv
// Purpose: self-checking bench for the surveillance command interpreter
// Assumes: replies are counted in bytes before CRC, as the coder sees them
// Notes: state starts from the nv_* reload; one task per scenario
`timescale 1ns/1ps
`include "surv_cmd_regs.svh"
module tb_rfid_tag_eas_custom_commands;
    localparam logic [7:0] MFG = 8'h5a; // arbitrary maker code
    localparam logic [7:0] ALM = 8'hae; // alarm command code
    logic mclk = 1'b0, link_clk = 1'b0, reset = 1'b1;
    logic rx_valid, rx_last, rx_fault, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_byte, tx_byte, rd_first, rd_count, clipped, wr_block;
    logic pwd_ok, nv_on, nv_lock, nv_sp, nv_fp, wr_req, wr_lk, wr_ad;
    logic s_on, s_lock, s_prot, f_prot, fast, rate_hi, single, abrt, werr;
    logic [15:0] nv_ident, ident;
    logic wl, ot, prs, nvw; // write-alike, option timing, pulses
    int n_prs = 0, n_nvw = 0;
    int err_total = 0, num_checks = 0, cyc = 0;
    initial forever #12.5 mclk = ~mclk;
    // link clock unrelated in phase to mclk
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    surv_cmd #(.MFG_CODE(MFG), .ALARM_CODE(ALM)) i_dut (.mclk(mclk),
        .reset(reset), .link_clk(link_clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last), .rx_fault(rx_fault),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_write_like(wl), .tx_option_timing(ot),
        .pwd_ok(pwd_ok), .nv_surv_on(nv_on), .nv_surv_lock(nv_lock),
        .nv_ident(nv_ident), .nv_surv_prot(nv_sp), .nv_fam_prot(nv_fp),
        .surv_on(s_on), .surv_lock(s_lock), .surv_identifier(ident),
        .surv_prot(s_prot), .fam_prot(f_prot), .nv_write(nvw),
        .page_read_start(prs), .page_read_fast(fast),
        .reply_rate_high(rate_hi), .reply_single_sub(single),
        .rd_first(rd_first), .rd_count(rd_count),
        .rd_count_clipped(clipped), .wr_req(wr_req), .wr_block(wr_block),
        .wr_block_locked(wr_lk), .wr_addressed(wr_ad), .wr_abort(abrt),
        .wr_err_reply(werr));
    reader_model i_rdr (.link_clk(link_clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last), .rx_fault(rx_fault),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
        .tx_ready(tx_ready));
    // count one-cycle pulses; a startup unknown counts as none
    always @(posedge mclk) begin
        n_prs <= n_prs + int'(prs);
        n_nvw <= n_nvw + int'(nvw);
    end
    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // reply bytes against a list; the length is compared first
    task automatic chk_rsp(input logic [7:0] exp[$]);
        chk(16'(i_rdr.got.size()), 16'(exp.size()));
        foreach (exp[i]) chk({8'h00, i_rdr.got[i]}, {8'h00, exp[i]});
    endtask : chk_rsp
    // one request, then wait well past the silence limit of the order
    task automatic req(input logic [7:0] q[$], input logic [7:0] r[$]);
        i_rdr.send(q, 1'b0);
        i_rdr.take(40);
        chk_rsp(r);
    endtask : req
    // alarm reply under a stalling coder: flags, 32 pattern bytes
    task automatic t_alarm(input logic [7:0] q[$]);
        i_rdr.slow = 1'b1;
        i_rdr.send(q, 1'b0);
        i_rdr.take(40);
        i_rdr.slow = 1'b0;
        chk(16'(i_rdr.got.size()), 16'd33);
        chk({8'h00, i_rdr.got[0]}, 16'h0000);
        chk({8'h00, i_rdr.got[1]}, 16'h002f);
        chk({8'h00, i_rdr.got[32]}, 16'h00ef);
    endtask : t_alarm
    task automatic t_mode();
        req('{8'h00, ALM, MFG}, '{});
        i_rdr.send('{8'h00, `CMD_SURV_ON, MFG}, 1'b1);
        i_rdr.take(40);
        chk_rsp('{});
        req('{8'h40, `CMD_SURV_ON, MFG}, '{8'h00});
        chk({15'h0, s_on}, 16'h1);
        chk({14'h0, wl, ot}, 16'h3);
        req('{8'h20, `CMD_SURV_OFF, MFG, 8'h01, 8'h02, 8'h03, 8'h04,
            8'h05, 8'h06, 8'h07, 8'h08}, '{8'h00});
        chk({15'h0, s_on}, 16'h0);
        req('{8'h00, `CMD_SURV_ON, MFG}, '{8'h00});
        t_alarm('{8'h00, ALM, MFG});
    endtask : t_mode
    task automatic t_ident();
        req('{8'h00, `CMD_IDENT_WR, MFG, 8'h34, 8'h12}, '{8'h00});
        chk(ident, 16'h1234);
        req('{8'h40, ALM, MFG, 8'h00}, '{8'h00, 8'h34, 8'h12});
        t_alarm('{8'h40, ALM, MFG, 8'h10, 8'h34, 8'h12});
        t_alarm('{8'h40, ALM, MFG, 8'h08, 8'h34});
        req('{8'h40, ALM, MFG, 8'h10, 8'h34, 8'h99}, '{});
    endtask : t_ident
    // password gating, protection enables, freeze, then refusals
    task automatic t_prot();
        req('{8'h10, `CMD_PROTECT, MFG}, '{8'h01, 8'h0f});
        @(posedge mclk) pwd_ok <= 1'b1;
        req('{8'h50, `CMD_PROTECT, MFG}, '{8'h00});
        chk({14'h0, s_prot, f_prot}, 16'h1);
        chk({14'h0, wl, ot}, 16'h2);
        req('{8'h00, `CMD_PROTECT, MFG}, '{8'h00});
        @(posedge mclk) pwd_ok <= 1'b0;
        req('{8'h10, `CMD_SURV_OFF, MFG}, '{8'h01, 8'h0f});
        req('{8'h10, `CMD_IDENT_WR, MFG, 8'h00, 8'h00},
            '{8'h01, 8'h0f});
        chk({13'h0, s_on, s_prot, f_prot}, 16'h7);
        @(posedge mclk) pwd_ok <= 1'b1;
        req('{8'h10, `CMD_SURV_FREEZE, MFG}, '{8'h00});
        req('{8'h10, `CMD_SURV_OFF, MFG}, '{8'h01, 8'h0f});
        req('{8'h10, `CMD_IDENT_WR, MFG, 8'h00, 8'h00},
            '{8'h01, 8'h0f});
        chk({ident[14:0], s_on}, 16'h2469);
        req('{8'h10, 8'hc5, MFG}, '{8'h01, 8'h0f});
        req('{8'h00, 8'hc5, MFG}, '{});
        req('{8'h14, 8'hc5, MFG}, '{});
        req('{8'h18, 8'hc5, MFG}, '{});
    endtask : t_prot
    task automatic t_fast(input logic [7:0] fl, input logic [15:0] exp);
        i_rdr.send('{fl, `CMD_FAST_PAGE, MFG, 8'h00, 8'h00, 8'h00}, 1'b0);
        i_rdr.take(40);
        chk({13'h0, fast, rate_hi, single}, exp);
    endtask : t_fast
    // one write request pulse, outcome one mclk later
    task automatic t_wr(input logic [7:0] b, input logic lk, input logic ad,
        input logic [15:0] exp);
        @(posedge mclk);
        wr_req <= 1'b1;
        wr_block <= b;
        wr_lk <= lk;
        wr_ad <= ad;
        @(posedge mclk) wr_req <= 1'b0;
        #1 chk({14'h0, abrt, werr}, exp);
    endtask : t_wr
    initial begin
        {pwd_ok, nv_on, nv_lock, nv_sp, nv_fp, wr_req, wr_lk, wr_ad} = 8'h00;
        {rd_first, rd_count, wr_block} = 24'h000000;
        nv_ident = 16'hbeef;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge link_clk);
        chk(ident, 16'hbeef);
        chk({12'h0, s_on, s_lock, s_prot, f_prot}, 16'h0);
        t_mode();
        t_ident();
        t_prot();
        t_fast(8'h06, 16'h7);
        t_fast(8'h04, 16'h5);
        chk(16'(n_prs), 16'd2);
        chk(16'(n_nvw), 16'd7);
        @(posedge mclk);
        rd_first <= 8'd14;
        rd_count <= 8'd8;
        repeat (2) @(posedge mclk);
        #1 chk({8'h00, clipped}, 16'd2);
        t_wr(8'd3, 1'b1, 1'b1, 16'h3);
        t_wr(8'd16, 1'b0, 1'b0, 16'h2);
        t_wr(8'd5, 1'b0, 1'b1, 16'h0);
        stop_test();
    end
    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            stop_test();
        end
    end
endmodule : tb_rfid_tag_eas_custom_commands
